//--- rtl/pwsirq_pkg.sv
`default_nettype none
package pwsirq_pkg;

  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;

  localparam logic [7:0]  MASK_OFS    = 8'h00;
  localparam logic [7:0]  STATUS_OFS  = 8'h04;
  localparam logic [7:0]  ACCUM_OFS   = 8'h08;
  localparam logic [7:0]  PULSE_OFS   = 8'h0c;

  localparam int          EV_LSB      = 10;
  localparam int          NUM_EV      = 5;
  localparam int          RA_BIT      = 10;
  localparam int          RB_BIT      = 11;
  localparam int          RC_BIT      = 12;
  localparam int          SUM2_BIT    = 13;
  localparam int          P1_BIT      = 14;

  localparam int          RSEL_BIT    = 7;
  localparam int          P1DIS_BIT   = 9;
  localparam int          P1SEL_LSB   = 0;
  localparam int          P1SEL_W     = 3;
  localparam int          NUM_P1_SRC  = 8;

  localparam logic [31:0] EV_BITS     = 32'h00007c00;
  localparam logic [31:0] ACCUM_BITS  = 32'h00000080;
  localparam logic [31:0] PULSE_BITS  = 32'h00000207;
  localparam logic [31:0] MASK_RST    = 32'h00000000;
  localparam logic [31:0] STATUS_RST  = 32'h00000000;
  localparam logic [31:0] ACCUM_RST   = 32'h00000000;
  localparam logic [31:0] PULSE_RST   = 32'h00000000;

  localparam int          WARM_CYC    = 3;

  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] status;
    logic [31:0] accum;
    logic [31:0] pulse;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        pulse_out1;
    logic [1:0]  warm;
  } pwsirq_state_t;

endpackage

`default_nettype wire

//--- rtl/pwsirq_chg_det.sv
`timescale 1ns/1ps
`default_nettype none

// Flags any change and any high-to-low step of each input bit.
// The first cycle after reset only loads the history.
module pwsirq_chg_det #(
  parameter int W = 5
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] sig,
  output logic      [W-1:0] chg,
  output logic      [W-1:0] fall
);

  typedef struct packed {
    logic [W-1:0] prev;
    logic         primed;
  } pwsirq_det_t;

  pwsirq_det_t det_reg;
  pwsirq_det_t det_next;

  always_comb begin
    det_next        = det_reg;
    det_next.prev   = sig;
    det_next.primed = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_reg <= '0;
    end else begin
      det_reg <= det_next;
    end
  end

  assign chg  = det_reg.primed ? (sig ^ det_reg.prev) : '0;
  assign fall = det_reg.primed ? (det_reg.prev & ~sig) : '0;

endmodule

`default_nettype wire

//--- rtl/pwsirq_top.sv
// Notes on behaviour
// - Mask bit 10, reset low, lets phase A reactive sign change interrupt.
// - Mask bit 11, reset low, lets phase B reactive sign change interrupt.
// - Mask bit 12, reset low, lets phase C reactive sign change interrupt.
// - Accumulation bit 7 picks fundamental or total reactive sign to watch.
// - Without reactive measurement the three reactive enables have no effect.
// - Mask bit 13, reset low, lets second path power sum sign change interrupt.
// - Mask bit 14 lets each falling edge of pulse output one interrupt.
// - Pulse output one interrupt still works while that pin is disabled.
// - Pulse mode bits 2 to 0 select the power driving pulse output one.
`timescale 1ns/1ps
`default_nettype none

module pwsirq_top #(
  parameter bit HAS_REACTIVE = 1'b1
) (
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [pwsirq_pkg::ADDR_W-1:0]      paddr,
  input  wire logic [pwsirq_pkg::DATA_W-1:0]      pwdata,
  input  wire logic [3:0]                         pstrb,
  output logic      [pwsirq_pkg::DATA_W-1:0]      prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  input  wire logic [2:0]                         react_sign_total,
  input  wire logic [2:0]                         react_sign_fund,
  input  wire logic                               sum2_sign,
  input  wire logic [pwsirq_pkg::NUM_P1_SRC-1:0]  p1_src_n,
  output logic                                    pulse_out1,
  output logic                                    irq
);

  pwsirq_pkg::pwsirq_state_t state_reg;
  pwsirq_pkg::pwsirq_state_t state_next;

  logic [2:0]                      react_sel;
  logic [pwsirq_pkg::P1SEL_W-1:0]  p1_sel;
  logic                            p1_src_sel;
  logic [pwsirq_pkg::NUM_EV-1:0]   det_in;
  logic [pwsirq_pkg::NUM_EV-1:0]   det_chg;
  logic [pwsirq_pkg::NUM_EV-1:0]   det_fall;
  logic [pwsirq_pkg::NUM_EV-1:0]   ev;
  logic                            acc_wait;
  logic                            acc_done;

  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] bits,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = lane_mask(strb) & bits;
    return (old & ~m) | (wd & m);
  endfunction

  // The reactive sign follows the chosen measurement.
  assign react_sel = state_reg.accum[pwsirq_pkg::RSEL_BIT] ?
                     react_sign_fund : react_sign_total;

  // The power type for pulse output one comes from the mode field.
  assign p1_sel = state_reg.pulse[pwsirq_pkg::P1SEL_LSB +: pwsirq_pkg::P1SEL_W];
  assign p1_src_sel = p1_src_n[p1_sel];

  assign det_in = {p1_src_sel, sum2_sign, react_sel};

  pwsirq_chg_det #(
    .W (pwsirq_pkg::NUM_EV)
  ) u_det (
    .pclk    (pclk),
    .presetn (presetn),
    .sig     (det_in),
    .chg     (det_chg),
    .fall    (det_fall)
  );

  // Reactive events vanish on the variant without reactive measurement.
  assign ev[2:0] = HAS_REACTIVE ? det_chg[2:0] : 3'h0;
  assign ev[3]   = det_chg[3];
  // The pulse edge is taken before the disable gate.
  assign ev[4]   = det_fall[4];

  assign acc_wait = psel & penable & ~state_reg.pready;
  assign acc_done = psel & penable & state_reg.pready;

  always_comb begin
    logic [31:0] clr;
    logic [31:0] set;
    clr            = '0;
    set            = '0;
    state_next     = state_reg;
    state_next.pready = acc_wait;
    state_next.pslverr = 1'b0;
    state_next.prdata  = '0;
    if (state_reg.warm != 2'(pwsirq_pkg::WARM_CYC)) begin
      state_next.warm = state_reg.warm + 2'h1;
    end
    if (acc_wait) begin
      state_next.prdata = '0;
      unique case (paddr)
        pwsirq_pkg::MASK_OFS:   state_next.prdata = state_reg.mask;
        pwsirq_pkg::STATUS_OFS: state_next.prdata = state_reg.status;
        pwsirq_pkg::ACCUM_OFS:  state_next.prdata = state_reg.accum;
        pwsirq_pkg::PULSE_OFS:  state_next.prdata = state_reg.pulse;
        default:                state_next.pslverr = 1'b1;
      endcase
      if (pwrite) begin
        state_next.prdata = '0;
      end
    end
    if (acc_done && pwrite) begin
      unique case (paddr)
        pwsirq_pkg::MASK_OFS: begin
          state_next.mask = merge(state_reg.mask, pwdata,
                                  pwsirq_pkg::EV_BITS, pstrb);
        end
        pwsirq_pkg::STATUS_OFS: begin
          clr = pwdata & lane_mask(pstrb) & pwsirq_pkg::EV_BITS;
        end
        pwsirq_pkg::ACCUM_OFS: begin
          state_next.accum = merge(state_reg.accum, pwdata,
                                   pwsirq_pkg::ACCUM_BITS, pstrb);
        end
        pwsirq_pkg::PULSE_OFS: begin
          state_next.pulse = merge(state_reg.pulse, pwdata,
                                   pwsirq_pkg::PULSE_BITS, pstrb);
        end
        default: begin
        end
      endcase
    end
    set[pwsirq_pkg::EV_LSB +: pwsirq_pkg::NUM_EV] = ev;
    // A new event in the clearing cycle stays set.
    state_next.status = (state_reg.status & ~clr) | set;
    // Reactive enables are ignored on the variant without them.
    state_next.irq = |(state_next.status & state_next.mask &
                       (HAS_REACTIVE ? pwsirq_pkg::EV_BITS
                                     : 32'h00006000));
    state_next.pulse_out1 = state_reg.pulse[pwsirq_pkg::P1DIS_BIT] ?
                            1'b1 : p1_src_sel;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg            <= '0;
      state_reg.mask       <= pwsirq_pkg::MASK_RST;
      state_reg.status     <= pwsirq_pkg::STATUS_RST;
      state_reg.accum      <= pwsirq_pkg::ACCUM_RST;
      state_reg.pulse      <= pwsirq_pkg::PULSE_RST;
      state_reg.pulse_out1 <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata     = state_reg.prdata;
  assign pready     = state_reg.pready;
  assign pslverr    = state_reg.pslverr;
  assign irq        = state_reg.irq;
  assign pulse_out1 = state_reg.pulse_out1;

  // Checks.
  logic warm_ok;
  logic wr_done;
  assign warm_ok = state_reg.warm == 2'(pwsirq_pkg::WARM_CYC);
  assign wr_done = acc_done & pwrite;

  property p_ra_set;
    @(posedge pclk) disable iff (!presetn)
      (warm_ok && HAS_REACTIVE && $stable(state_reg.accum) &&
       react_sel[0] != $past(react_sel[0]))
      |=> state_reg.status[pwsirq_pkg::RA_BIT];
  endproperty
  a_ra_set: assert property (p_ra_set)
    else $error("Phase A reactive sign change not flagged.");

  property p_rb_masked;
    @(posedge pclk) disable iff (!presetn)
      (state_reg.status == 32'h00000800 && !state_reg.mask[11])
      |-> !irq;
  endproperty
  a_rb_masked: assert property (p_rb_masked)
    else $error("Masked phase B event raised the interrupt.");

  property p_rc_raise;
    @(posedge pclk) disable iff (!presetn)
      (HAS_REACTIVE && warm_ok && ev[2] &&
       state_reg.mask[pwsirq_pkg::RC_BIT] &&
       !(acc_done && pwrite && paddr == pwsirq_pkg::MASK_OFS))
      |=> irq;
  endproperty
  a_rc_raise: assert property (p_rc_raise)
    else $error("Enabled phase C event did not raise the interrupt.");

  property p_src_fund;
    @(posedge pclk) disable iff (!presetn)
      (warm_ok && HAS_REACTIVE &&
       state_reg.accum[pwsirq_pkg::RSEL_BIT] &&
       $stable(state_reg.accum) && $changed(react_sign_fund[1]))
      |=> state_reg.status[pwsirq_pkg::RB_BIT];
  endproperty
  a_src_fund: assert property (p_src_fund)
    else $error("Fundamental reactive sign change not flagged.");

  property p_no_react;
    @(posedge pclk) disable iff (!presetn)
      !HAS_REACTIVE |-> (state_reg.status[12:10] == 3'h0);
  endproperty
  a_no_react: assert property (p_no_react)
    else $error("Reactive flag set on variant without reactive power.");

  property p_sum2;
    @(posedge pclk) disable iff (!presetn)
      (warm_ok && $changed(sum2_sign))
      |=> state_reg.status[pwsirq_pkg::SUM2_BIT];
  endproperty
  a_sum2: assert property (p_sum2)
    else $error("Second path sum sign change not flagged.");

  property p_p1_fall;
    @(posedge pclk) disable iff (!presetn)
      (warm_ok && $stable(state_reg.pulse) && $fell(p1_src_sel))
      |=> state_reg.status[pwsirq_pkg::P1_BIT];
  endproperty
  a_p1_fall: assert property (p_p1_fall)
    else $error("Pulse output one falling edge not flagged.");

  property p_p1_dis;
    @(posedge pclk) disable iff (!presetn)
      (state_reg.pulse[pwsirq_pkg::P1DIS_BIT] && ev[4])
      |=> (pulse_out1 && state_reg.status[pwsirq_pkg::P1_BIT]);
  endproperty
  a_p1_dis: assert property (p_p1_dis)
    else $error("Disabled pulse output lost its event or drove low.");

  property p_p1_sel;
    @(posedge pclk) disable iff (!presetn)
      !state_reg.pulse[pwsirq_pkg::P1DIS_BIT]
      |=> (pulse_out1 == $past(p1_src_sel));
  endproperty
  a_p1_sel: assert property (p_p1_sel)
    else $error("Pulse output one does not follow the selected power.");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
      HAS_REACTIVE |-> (irq == |(state_reg.status & state_reg.mask));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("Interrupt level disagrees with flags and enables.");

  property p_ready_one;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready) |=> pready ##1 !pready;
  endproperty
  a_ready_one: assert property (p_ready_one)
    else $error("Bus answer not a single wait cycle.");

  c_irq_rise:  cover property (@(posedge pclk) disable iff (!presetn)
                               $rose(irq));
  c_w1c:       cover property (@(posedge pclk) disable iff (!presetn)
                               $fell(irq) && $past(wr_done));
  c_p1_dis_ev: cover property (@(posedge pclk) disable iff (!presetn)
                               state_reg.pulse[pwsirq_pkg::P1DIS_BIT] &&
                               ev[4]);
  c_fund_ev:   cover property (@(posedge pclk) disable iff (!presetn)
                               state_reg.accum[pwsirq_pkg::RSEL_BIT] &&
                               |ev[2:0]);

endmodule

`default_nettype wire

//--- verif/pwsirq_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Host side of the interrupt line: counts each new request it sees.
module pwsirq_host_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       irq,
  output logic      [7:0] irq_seen
);
  logic irq_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q    <= 1'b0;
      irq_seen <= 8'h00;
    end else begin
      irq_q <= irq;
      if (irq && !irq_q) begin
        irq_seen <= irq_seen + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0]  react_sign_total = 3'h0;
  logic [2:0]  react_sign_fund = 3'h0;
  logic        sum2_sign = 1'b0;
  logic [7:0]  p1_src_n = 8'hff;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pulse_out1;
  logic        irq;
  logic        irq_nr;
  logic [7:0]  irq_seen;
  int          errors = 0;
  int          tests_run = 0;
  logic [7:0]  ofs [4] = '{pwsirq_pkg::MASK_OFS, pwsirq_pkg::STATUS_OFS,
                           pwsirq_pkg::ACCUM_OFS, pwsirq_pkg::PULSE_OFS};
  logic [31:0] rwb [4] = '{pwsirq_pkg::EV_BITS, 32'h0,
                           pwsirq_pkg::ACCUM_BITS, pwsirq_pkg::PULSE_BITS};

  always #20 pclk = ~pclk;

  pwsirq_top pwsirq_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .react_sign_total(react_sign_total), .react_sign_fund(react_sign_fund),
    .sum2_sign(sum2_sign), .p1_src_n(p1_src_n),
    .pulse_out1(pulse_out1), .irq(irq)
  );

  // Variant without reactive measurement, sharing the same bus and inputs.
  pwsirq_top #(.HAS_REACTIVE(1'b0)) pwsirq_top_inst_nr (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(), .pready(), .pslverr(),
    .react_sign_total(react_sign_total), .react_sign_fund(react_sign_fund),
    .sum2_sign(sum2_sign), .p1_src_n(p1_src_n),
    .pulse_out1(), .irq(irq_nr)
  );

  pwsirq_host_model pwsirq_host_model_inst (
    .pclk(pclk), .presetn(presetn), .irq(irq), .irq_seen(irq_seen)
  );

  task automatic stop_test();
    $display("tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      errors++;
      stop_test();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  function automatic logic [31:0] ev(input int i);
    return 32'h1 << (pwsirq_pkg::EV_LSB + i);
  endfunction

  task automatic fire(input int i);
    @(posedge pclk);
    if (i < 3) react_sign_total[i] <= ~react_sign_total[i];
    else if (i == 3) sum2_sign <= ~sum2_sign;
    else p1_src_n[0] <= 1'b0;
  endtask

  initial begin
    int          i;
    int          j;
    logic [31:0] d;
    void'($urandom(99010));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 4; i++) rd(ofs[i], 32'h0, 1'b0);
    for (i = 0; i < 4; i++) begin
      d = $urandom();
      wr(ofs[i], d);
      if (i != 1) rd(ofs[i], d & rwb[i], 1'b0);
      wr(ofs[i], 32'h0);
    end
    wr(pwsirq_pkg::STATUS_OFS, 32'hffffffff);
    rd(pwsirq_pkg::STATUS_OFS, 32'h0, 1'b0);
    rd(8'h10, 32'h0, 1'b1);
    // Each event: masked first, then enabled, then cleared.
    for (i = 0; i < 5; i++) begin
      fire(i);
      tick(3);
      chk({31'h0, irq}, 32'h0);
      rd(pwsirq_pkg::STATUS_OFS, ev(i), 1'b0);
      wr(pwsirq_pkg::MASK_OFS, ev(i));
      tick(1);
      chk({31'h0, irq}, 32'h1);
      chk({31'h0, irq_nr}, {31'h0, i > 2});
      wr(pwsirq_pkg::STATUS_OFS, ev(i));
      tick(1);
      chk({31'h0, irq}, 32'h0);
      wr(pwsirq_pkg::MASK_OFS, 32'h0);
    end
    chk({24'h0, irq_seen}, 32'h5);
    // Enabled first: the event alone raises the line.
    wr(pwsirq_pkg::MASK_OFS, ev(2));
    fire(2);
    tick(2);
    chk({31'h0, irq}, 32'h1);
    chk({31'h0, irq_nr}, 32'h0);
    wr(pwsirq_pkg::STATUS_OFS, ev(2));
    wr(pwsirq_pkg::MASK_OFS, 32'h0);
    // Switch the reactive source to fundamental.
    @(posedge pclk);
    react_sign_fund <= react_sign_total;
    wr(pwsirq_pkg::ACCUM_OFS, pwsirq_pkg::ACCUM_BITS);
    fire(1);
    tick(3);
    rd(pwsirq_pkg::STATUS_OFS, 32'h0, 1'b0);
    @(posedge pclk);
    react_sign_fund[1] <= ~react_sign_fund[1];
    tick(3);
    rd(pwsirq_pkg::STATUS_OFS, ev(1), 1'b0);
    wr(pwsirq_pkg::STATUS_OFS, 32'hffffffff);
    // Pulse output one: disabled pin, random source, falling edges.
    @(posedge pclk);
    p1_src_n <= 8'hff;
    j = $urandom_range(7, 1);
    wr(pwsirq_pkg::PULSE_OFS, 32'h00000200 | 32'(j));
    tick(2);
    rd(pwsirq_pkg::STATUS_OFS, 32'h0, 1'b0);
    @(posedge pclk);
    p1_src_n[j] <= 1'b0;
    tick(3);
    chk({31'h0, pulse_out1}, 32'h1);
    rd(pwsirq_pkg::STATUS_OFS, ev(4), 1'b0);
    wr(pwsirq_pkg::STATUS_OFS, ev(4));
    @(posedge pclk);
    p1_src_n <= 8'hfe;
    tick(3);
    rd(pwsirq_pkg::STATUS_OFS, 32'h0, 1'b0);
    wr(pwsirq_pkg::PULSE_OFS, 32'(j));
    tick(2);
    chk({31'h0, pulse_out1}, 32'h1);
    @(posedge pclk);
    p1_src_n[j] <= 1'b0;
    tick(2);
    chk({31'h0, pulse_out1}, 32'h0);
    stop_test();
  end
endmodule

`default_nettype wire
